// file: logic/ldca_load_filter.sv
// Load measurement filter: passes each reading or the mean of four readings
`timescale 1ns/10ps
module ldca_load_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic i_enable,
  // Raw reading, one per full step
  input wire logic i_sample_valid,
  input wire logic [ldca_pkg::LOAD_W-1:0] i_sample,
  // Measurement output
  output logic o_valid,
  output logic [ldca_pkg::LOAD_W-1:0] o_value
);

  logic [ldca_pkg::LOAD_W+1:0] sum_reg;
  logic [1:0] count_reg;
  logic enable_reg;
  logic [ldca_pkg::LOAD_W+1:0] sum_next;

  assign sum_next = sum_reg + {2'h0, i_sample};

  always_ff @(posedge clk) begin
    if (rst) begin
      sum_reg <= '0;
      count_reg <= 2'h0;
      enable_reg <= 1'b0;
      o_valid <= 1'b0;
      o_value <= '0;
    end else if (ce) begin
      enable_reg <= i_enable;
      o_valid <= 1'b0;
      // A mode change restarts the group so no mixed average leaks out
      if (enable_reg != i_enable) begin
        sum_reg <= '0;
        count_reg <= 2'h0;
      end else if (i_sample_valid) begin
        if (!i_enable) begin
          o_valid <= 1'b1;
          o_value <= i_sample;
        end else if (count_reg == 2'h3) begin
          o_valid <= 1'b1;
          o_value <= sum_next[ldca_pkg::LOAD_W+1:ldca_pkg::FILTER_SHIFT];
          sum_reg <= '0;
          count_reg <= 2'h0;
        end else begin
          sum_reg <= sum_next;
          count_reg <= count_reg + 2'h1;
        end
      end
    end
  end

endmodule : ldca_load_filter

// file: logic/ldca_top.sv
// Load detection, stop on stall and load adaptive coil current control
// Overview of operation
// - Load measurement refreshes once per full step, or once per four full steps with the filter enabled
// - Filter enable averages four successive readings
// - Zero reading with stop enabled commands stop
// - Stall halts ramp, actual velocity forced zero
// - Stall flag set in driver status register
// - Read/write-back clears event; restart after wait
// - Stall detection only above lower velocity threshold
// - Lower load threshold is 4-bit unsigned
// - Effective lower threshold is setting times 32
// - Load below lower threshold raises current scale
// - Upper threshold is (lower+span+1) times 32
// - Enough readings at/above upper lower the scale
// - Increment step selectable as 1,2,4,8
// - Decrement every 32,8,2,1 high readings
// - Minimum scale half or quarter of run current
// - Adaptation off below lower velocity threshold
`timescale 1ns/10ps
module ldca_top (
  // Clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_CLK_EN,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Motor side
  input wire logic I_FULLSTEP,
  input wire logic [ldca_pkg::LOAD_W-1:0] I_LOAD_SAMPLE,
  input wire logic [ldca_pkg::VEL_W-1:0] I_STEP_INTERVAL,
  output logic O_RAMP_HALT,
  output logic [ldca_pkg::SCALE_W-1:0] O_CURRENT_SCALE,
  // Interrupt
  output logic O_IRQ
);

  // Threshold times 32, widened to hold (15+15+1)*32
  function automatic logic [ldca_pkg::LOAD_W:0] times32(input logic [5:0] v);
    times32 = {v, 5'h00};
  endfunction : times32

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    lane_merge = r;
  endfunction : lane_merge

  // Registers written by software
  logic [2:0] config_reg;
  logic [12:0] adapt_reg;
  logic [4:0] run_current_reg;
  logic [19:0] vel_thresh_reg;
  logic [15:0] zero_wait_reg;
  logic [2:0] irq_mask_reg;

  // Block state
  logic [ldca_pkg::LOAD_W-1:0] load_meas_reg;
  logic stall_flag_reg;
  logic stall_event_reg;
  logic [2:0] irq_status_reg;
  logic [ldca_pkg::SCALE_W-1:0] scale_reg;
  logic [4:0] dec_count_reg;
  logic [15:0] wait_count_reg;
  logic [7:0] unit_count_reg;
  ldca_pkg::ldca_ramp_state_t ramp_state_reg;
  ldca_pkg::ldca_ramp_state_t ramp_state_next;

  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic [31:0] rd_data;
  logic event_clear;

  // Filter output
  logic meas_valid;
  logic [ldca_pkg::LOAD_W-1:0] meas_value;

  // Derived settings
  logic [3:0] lower_set;
  logic [3:0] span_set;
  logic [1:0] inc_set;
  logic [1:0] dec_set;
  logic min_sel;
  logic vel_active;
  logic adapt_active;
  logic [ldca_pkg::LOAD_W:0] lower_thresh;
  logic [ldca_pkg::LOAD_W:0] upper_thresh;
  logic [ldca_pkg::SCALE_W-1:0] min_scale;
  logic [ldca_pkg::SCALE_W:0] scale_sum;
  logic [ldca_pkg::SCALE_W-1:0] inc_width;
  logic [4:0] dec_period;
  logic stall_seen;
  logic raise_seen;

  assign wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign wb_wr = wb_req & I_WB_WE;
  assign wb_rd = wb_req & ~I_WB_WE;

  assign lower_set = adapt_reg[ldca_pkg::ADP_LOWER_LSB +: 4];
  assign span_set = adapt_reg[ldca_pkg::ADP_SPAN_LSB +: 4];
  assign inc_set = adapt_reg[ldca_pkg::ADP_INC_LSB +: 2];
  assign dec_set = adapt_reg[ldca_pkg::ADP_DEC_LSB +: 2];
  assign min_sel = adapt_reg[ldca_pkg::ADP_MIN_SEL_BIT];

  // Faster motion means a shorter step interval than the threshold
  assign vel_active = I_STEP_INTERVAL < vel_thresh_reg;
  assign adapt_active = vel_active & (lower_set != 4'h0);

  assign lower_thresh = times32({2'h0, lower_set});
  assign upper_thresh = times32(6'({2'h0, lower_set} + {2'h0, span_set} + 6'h01));

  assign min_scale = min_sel ? (run_current_reg >> 2) : (run_current_reg >> 1);
  assign inc_width = ldca_pkg::SCALE_W'(5'h01 << inc_set);
  assign scale_sum = {1'b0, scale_reg} + {1'b0, inc_width};

  always_comb begin
    case (dec_set)
      2'h0: dec_period = 5'h1F;
      2'h1: dec_period = 5'h07;
      2'h2: dec_period = 5'h01;
      default: dec_period = 5'h00;
    endcase
  end

  // Write-back of the ramp status with the event bit set clears it
  assign event_clear = wb_wr && (I_WB_ADR == ldca_pkg::ADDR_RAMP_STATUS) && I_WB_SEL[0]
                       && I_WB_DAT[ldca_pkg::RAMP_STALL_EVENT_BIT];

  assign stall_seen = meas_valid && (meas_value == '0) && config_reg[ldca_pkg::CFG_STOP_ON_STALL_BIT]
                      && vel_active && (ramp_state_reg != ldca_pkg::LDCA_HALTED);

  assign raise_seen = meas_valid && adapt_active && ({1'b0, meas_value} < lower_thresh);

  ldca_load_filter u_filter (
    .clk(I_CLK_SYS),
    .rst(I_SYS_RST),
    .ce(I_CLK_EN),
    .i_enable(config_reg[ldca_pkg::CFG_FILTER_EN_BIT]),
    .i_sample_valid(I_FULLSTEP),
    .i_sample(I_LOAD_SAMPLE),
    .o_valid(meas_valid),
    .o_value(meas_value)
  );

  // Software registers
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      config_reg <= ldca_pkg::RST_CONFIG;
      adapt_reg <= ldca_pkg::RST_ADAPT;
      run_current_reg <= ldca_pkg::RST_RUN_CURRENT;
      vel_thresh_reg <= ldca_pkg::RST_VEL_THRESH;
      zero_wait_reg <= ldca_pkg::RST_ZERO_WAIT;
      irq_mask_reg <= ldca_pkg::RST_IRQ_MASK;
    end else if (I_CLK_EN && wb_wr) begin
      if (I_WB_ADR == ldca_pkg::ADDR_CONFIG) begin
        config_reg <= 3'(lane_merge({29'h0, config_reg}, I_WB_DAT, I_WB_SEL));
      end else if (I_WB_ADR == ldca_pkg::ADDR_ADAPT) begin
        adapt_reg <= 13'(lane_merge({19'h0, adapt_reg}, I_WB_DAT, I_WB_SEL));
      end else if (I_WB_ADR == ldca_pkg::ADDR_RUN_CURRENT) begin
        run_current_reg <= 5'(lane_merge({27'h0, run_current_reg}, I_WB_DAT, I_WB_SEL));
      end else if (I_WB_ADR == ldca_pkg::ADDR_VEL_THRESH) begin
        vel_thresh_reg <= 20'(lane_merge({12'h0, vel_thresh_reg}, I_WB_DAT, I_WB_SEL));
      end else if (I_WB_ADR == ldca_pkg::ADDR_ZERO_WAIT) begin
        zero_wait_reg <= 16'(lane_merge({16'h0, zero_wait_reg}, I_WB_DAT, I_WB_SEL));
      end else if (I_WB_ADR == ldca_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= 3'(lane_merge({29'h0, irq_mask_reg}, I_WB_DAT, I_WB_SEL));
      end
    end
  end

  // Read mux, unmapped addresses read as zero
  always_comb begin
    rd_data = 32'h00000000;
    if (I_WB_ADR == ldca_pkg::ADDR_CONFIG) begin
      rd_data = {29'h0, config_reg};
    end else if (I_WB_ADR == ldca_pkg::ADDR_ADAPT) begin
      rd_data = {19'h0, adapt_reg};
    end else if (I_WB_ADR == ldca_pkg::ADDR_RUN_CURRENT) begin
      rd_data = {27'h0, run_current_reg};
    end else if (I_WB_ADR == ldca_pkg::ADDR_VEL_THRESH) begin
      rd_data = {12'h0, vel_thresh_reg};
    end else if (I_WB_ADR == ldca_pkg::ADDR_ZERO_WAIT) begin
      rd_data = {16'h0, zero_wait_reg};
    end else if (I_WB_ADR == ldca_pkg::ADDR_LOAD_MEAS) begin
      rd_data = {22'h0, load_meas_reg};
    end else if (I_WB_ADR == ldca_pkg::ADDR_DRIVER_STATUS_REGISTER) begin
      rd_data[ldca_pkg::DRV_STALL_BIT] = stall_flag_reg;
      rd_data[ldca_pkg::DRV_ADAPT_ACTIVE_BIT] = adapt_active;
      rd_data[ldca_pkg::DRV_VEL_ACTIVE_BIT] = vel_active;
      rd_data[ldca_pkg::DRV_SCALE_LSB +: ldca_pkg::SCALE_W] = scale_reg;
    end else if (I_WB_ADR == ldca_pkg::ADDR_RAMP_STATUS) begin
      rd_data[ldca_pkg::RAMP_STALL_EVENT_BIT] = stall_event_reg;
      rd_data[ldca_pkg::RAMP_HALT_BIT] = O_RAMP_HALT;
    end else if (I_WB_ADR == ldca_pkg::ADDR_IRQ_STATUS) begin
      rd_data = {29'h0, irq_status_reg};
    end else if (I_WB_ADR == ldca_pkg::ADDR_IRQ_MASK) begin
      rd_data = {29'h0, irq_mask_reg};
    end
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else if (I_CLK_EN) begin
      O_WB_ACK <= wb_req;
      if (wb_rd) begin
        O_WB_DAT <= rd_data;
      end
    end
  end

  // Latest load measurement
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      load_meas_reg <= '0;
    end else if (I_CLK_EN && meas_valid) begin
      load_meas_reg <= meas_value;
    end
  end

  // Stop-on-stall sequence
  always_comb begin
    ramp_state_next = ramp_state_reg;
    case (ramp_state_reg)
      ldca_pkg::LDCA_RUN: begin
        if (stall_seen) begin
          ramp_state_next = ldca_pkg::LDCA_HALTED;
        end
      end
      ldca_pkg::LDCA_HALTED: begin
        // Disabling stop on stall also releases the motor
        if (event_clear || !config_reg[ldca_pkg::CFG_STOP_ON_STALL_BIT]) begin
          ramp_state_next = ldca_pkg::LDCA_ZERO_WAIT;
        end
      end
      ldca_pkg::LDCA_ZERO_WAIT: begin
        if (wait_count_reg == 16'h0000 && unit_count_reg == 8'h00) begin
          ramp_state_next = ldca_pkg::LDCA_RUN;
        end
      end
      default: begin
        ramp_state_next = ldca_pkg::LDCA_RUN;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ramp_state_reg <= ldca_pkg::LDCA_RUN;
      O_RAMP_HALT <= 1'b0;
    end else if (I_CLK_EN) begin
      ramp_state_reg <= ramp_state_next;
      // Halt forces the actual velocity of the ramp to zero
      O_RAMP_HALT <= (ramp_state_next != ldca_pkg::LDCA_RUN);
    end
  end

  // Zero wait timer, loaded on entry to the wait
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      wait_count_reg <= 16'h0000;
      unit_count_reg <= 8'h00;
    end else if (I_CLK_EN) begin
      if (ramp_state_reg != ldca_pkg::LDCA_ZERO_WAIT) begin
        wait_count_reg <= zero_wait_reg;
        unit_count_reg <= 8'(ldca_pkg::ZERO_WAIT_UNIT_CYC - 1);
      end else if (unit_count_reg != 8'h00) begin
        unit_count_reg <= unit_count_reg - 8'h01;
      end else if (wait_count_reg != 16'h0000) begin
        wait_count_reg <= wait_count_reg - 16'h0001;
        unit_count_reg <= 8'(ldca_pkg::ZERO_WAIT_UNIT_CYC - 1);
      end
    end
  end

  // Stall event and flag: a new stall wins over a clear in the same cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      stall_event_reg <= 1'b0;
      stall_flag_reg <= 1'b0;
    end else if (I_CLK_EN) begin
      if (stall_seen) begin
        stall_event_reg <= 1'b1;
        stall_flag_reg <= 1'b1;
      end else begin
        if (event_clear) begin
          stall_event_reg <= 1'b0;
        end
        if (ramp_state_next == ldca_pkg::LDCA_RUN) begin
          stall_flag_reg <= 1'b0;
        end
      end
    end
  end

  // Adaptive current scale
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      scale_reg <= ldca_pkg::RST_RUN_CURRENT;
      dec_count_reg <= 5'h00;
    end else if (I_CLK_EN) begin
      if (!adapt_active) begin
        scale_reg <= run_current_reg;
        dec_count_reg <= 5'h00;
      end else if (scale_reg > run_current_reg) begin
        scale_reg <= run_current_reg;
      end else if (scale_reg < min_scale) begin
        scale_reg <= min_scale;
      end else if (meas_valid) begin
        if ({1'b0, meas_value} < lower_thresh) begin
          dec_count_reg <= 5'h00;
          // Saturate at the run current instead of wrapping
          if (scale_sum > {1'b0, run_current_reg}) begin
            scale_reg <= run_current_reg;
          end else begin
            scale_reg <= scale_sum[ldca_pkg::SCALE_W-1:0];
          end
        end else if ({1'b0, meas_value} >= upper_thresh) begin
          if (dec_count_reg >= dec_period) begin
            dec_count_reg <= 5'h00;
            if (scale_reg > min_scale) begin
              scale_reg <= scale_reg - 5'h01;
            end
          end else begin
            dec_count_reg <= dec_count_reg + 5'h01;
          end
        end else begin
          // Only uninterrupted high readings count toward a decrement
          dec_count_reg <= 5'h00;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_CURRENT_SCALE <= ldca_pkg::RST_RUN_CURRENT;
    end else if (I_CLK_EN) begin
      O_CURRENT_SCALE <= scale_reg;
    end
  end

  // Interrupt status: read clears, a new event in the same cycle wins
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      irq_status_reg <= 3'h0;
      O_IRQ <= 1'b0;
    end else if (I_CLK_EN) begin
      irq_status_reg <= ((wb_rd && I_WB_ADR == ldca_pkg::ADDR_IRQ_STATUS) ? 3'h0 : irq_status_reg)
                        | {raise_seen, meas_valid, stall_seen};
      O_IRQ <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule : ldca_top

// file: shared/ldca_pkg.sv
// Package with register map, field layout, reset values and timing constants of the load adaptive block
package ldca_pkg;

  // Word offsets on the register bus (byte addresses)
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_ADAPT = 8'h04;
  localparam logic [7:0] ADDR_RUN_CURRENT = 8'h08;
  localparam logic [7:0] ADDR_VEL_THRESH = 8'h0C;
  localparam logic [7:0] ADDR_ZERO_WAIT = 8'h10;
  localparam logic [7:0] ADDR_LOAD_MEAS = 8'h14;
  localparam logic [7:0] ADDR_DRIVER_STATUS_REGISTER = 8'h18;
  localparam logic [7:0] ADDR_RAMP_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // Configuration register fields
  localparam int CFG_FILTER_EN_BIT = 0;
  localparam int CFG_STOP_ON_STALL_BIT = 1;

  // Adaptive current register fields
  localparam int ADP_LOWER_LSB = 0;
  localparam int ADP_SPAN_LSB = 4;
  localparam int ADP_INC_LSB = 8;
  localparam int ADP_DEC_LSB = 10;
  localparam int ADP_MIN_SEL_BIT = 12;

  // Driver status fields
  localparam int DRV_STALL_BIT = 24;
  localparam int DRV_SCALE_LSB = 16;
  localparam int DRV_ADAPT_ACTIVE_BIT = 25;
  localparam int DRV_VEL_ACTIVE_BIT = 26;

  // Ramp status and interrupt fields
  localparam int RAMP_STALL_EVENT_BIT = 0;
  localparam int RAMP_HALT_BIT = 1;
  localparam int IRQ_STALL_BIT = 0;
  localparam int IRQ_MEAS_BIT = 1;
  localparam int IRQ_RAISE_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // Widths
  localparam int LOAD_W = 10;
  localparam int SCALE_W = 5;
  localparam int VEL_W = 20;
  localparam int WAIT_W = 16;

  // Reset values
  localparam logic [2:0] RST_CONFIG = 3'h0;
  localparam logic [12:0] RST_ADAPT = 13'h0000;
  localparam logic [4:0] RST_RUN_CURRENT = 5'h1F;
  localparam logic [19:0] RST_VEL_THRESH = 20'h00000;
  localparam logic [15:0] RST_ZERO_WAIT = 16'h0000;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // Threshold scale factor is a shift by five (times 32)
  localparam int THRESH_SHIFT = 5;
  // Readings combined by the filter, as a shift of two
  localparam int FILTER_SHIFT = 2;

  // Clock and zero wait unit: one wait count lasts this long
  localparam int CLK_PERIOD_NS = 10;
  localparam int ZERO_WAIT_UNIT_NS = 10;
  localparam int ZERO_WAIT_UNIT_CYC = (ZERO_WAIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LDCA_RUN = 2'b00,
    LDCA_HALTED = 2'b01,
    LDCA_ZERO_WAIT = 2'b10
  } ldca_ramp_state_t;

endpackage : ldca_pkg

// file: tb/ldca_motor_model.sv
// Behavioural model of the motor and driver stage reporting one load reading per full step
`timescale 1ns/10ps
module ldca_motor_model (
  // Clock
  input wire logic i_clk,
  // From the block
  input wire logic i_halt,
  // To the block
  output logic o_fullstep,
  output logic [ldca_pkg::LOAD_W-1:0] o_load,
  output logic [ldca_pkg::VEL_W-1:0] o_interval
);
  logic [ldca_pkg::VEL_W-1:0] speed_interval = 20'h00064;
  initial begin
    o_fullstep = 1'b0;
    o_load = 10'h3FF;
  end
  // A halted rotor has no velocity, so it reports the slowest interval
  always_comb o_interval = i_halt ? 20'hFFFFF : speed_interval;
  // Reading is valid only with the pulse; afterwards the lines show its inverse
  task automatic step(input logic [ldca_pkg::LOAD_W-1:0] v);
    if (i_halt !== 1'b1) begin
      @(posedge i_clk);
      o_fullstep <= 1'b1;
      o_load <= v;
      @(posedge i_clk);
      o_fullstep <= 1'b0;
      o_load <= ~v;
    end
  endtask : step
endmodule : ldca_motor_model

// file: tb/ldca_props.sv
// Checker of bus handshake, stall halt and current scale behaviour of the load adaptive block
`timescale 1ns/10ps
module ldca_props (
  // Clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_CLK_EN,
  // Bus
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic O_WB_ACK,
  // Motor side and interrupt
  input wire logic I_FULLSTEP,
  input wire logic [ldca_pkg::LOAD_W-1:0] I_LOAD_SAMPLE,
  input wire logic [ldca_pkg::VEL_W-1:0] I_STEP_INTERVAL,
  input wire logic O_RAMP_HALT,
  input wire logic [ldca_pkg::SCALE_W-1:0] O_CURRENT_SCALE,
  input wire logic O_IRQ
);
  logic wr;
  logic [4:0] run_reg;
  logic [3:0] lower_reg;
  logic [2:0] mask_reg;
  logic [19:0] vel_reg;
  logic [19:0] intv_reg;
  logic [3:0] zero_age_reg;
  logic [3:0] cause_age_reg;
  logic release_reg;
  assign wr = I_CLK_EN && I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST || !I_CLK_EN);
  // Shadow copies of the settings the assertions depend on
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      run_reg <= ldca_pkg::RST_RUN_CURRENT;
      lower_reg <= 4'h0;
      mask_reg <= ldca_pkg::RST_IRQ_MASK;
      vel_reg <= ldca_pkg::RST_VEL_THRESH;
    end else if (wr && I_WB_SEL[0]) begin
      if (I_WB_ADR == ldca_pkg::ADDR_RUN_CURRENT) run_reg <= I_WB_DAT[4:0];
      if (I_WB_ADR == ldca_pkg::ADDR_ADAPT) lower_reg <= I_WB_DAT[3:0];
      if (I_WB_ADR == ldca_pkg::ADDR_IRQ_MASK) mask_reg <= I_WB_DAT[2:0];
      if (I_WB_ADR == ldca_pkg::ADDR_VEL_THRESH) vel_reg <= I_WB_DAT[19:0];
    end
  end
  // Ages since the last possible cause, saturating so they never wrap
  always_ff @(posedge I_CLK_SYS) begin
    intv_reg <= I_STEP_INTERVAL;
    if (I_SYS_RST || wr || I_FULLSTEP || I_STEP_INTERVAL != intv_reg) cause_age_reg <= 4'h0;
    else if (cause_age_reg != 4'hF) cause_age_reg <= cause_age_reg + 4'h1;
    if (I_FULLSTEP && I_LOAD_SAMPLE == 10'h000 && I_STEP_INTERVAL < vel_reg) zero_age_reg <= 4'h0;
    else if (I_SYS_RST) zero_age_reg <= 4'hF;
    else if (zero_age_reg != 4'hF) zero_age_reg <= zero_age_reg + 4'h1;
    if (I_SYS_RST || !O_RAMP_HALT) release_reg <= 1'b0;
    if (wr && (I_WB_ADR == ldca_pkg::ADDR_RAMP_STATUS || I_WB_ADR == ldca_pkg::ADDR_CONFIG)) release_reg <= 1'b1;
  end
  ack_one_cycle_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held too long");
  ack_follows_req_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("ack missing");
  ack_needs_req_a: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB)) else $error("ack unasked");
  halt_needs_zero_a: assert property ($rose(O_RAMP_HALT) |-> zero_age_reg <= 4'h8)
    else $error("halt without a fast zero reading");
  halt_release_a: assert property ($fell(O_RAMP_HALT) |-> release_reg)
    else $error("halt released without software clear");
  scale_cause_a: assert property ($changed(O_CURRENT_SCALE) |-> cause_age_reg <= 4'h8)
    else $error("scale moved without a reading or write");
  scale_max_a: assert property (cause_age_reg > 4'h8 |-> O_CURRENT_SCALE <= run_reg)
    else $error("scale above run current");
  scale_idle_off_a: assert property (lower_reg == 4'h0 && cause_age_reg > 4'h8 |-> O_CURRENT_SCALE == run_reg)
    else $error("scale moved with adaptation off");
  irq_masked_a: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !O_IRQ)
    else $error("interrupt while all masked");
  cover property ($rose(O_RAMP_HALT));
  cover property ($fell(O_RAMP_HALT));
  cover property (O_CURRENT_SCALE < run_reg);
  cover property (O_IRQ);
endmodule : ldca_props

bind ldca_top ldca_props u_props (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_CLK_EN(I_CLK_EN),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
  .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_FULLSTEP(I_FULLSTEP), .I_LOAD_SAMPLE(I_LOAD_SAMPLE),
  .I_STEP_INTERVAL(I_STEP_INTERVAL), .O_RAMP_HALT(O_RAMP_HALT), .O_CURRENT_SCALE(O_CURRENT_SCALE), .O_IRQ(O_IRQ));

// file: tb/ldca_top_tb.sv
// Self-checking testbench of the load adaptive block driven through its bus and a motor model
`timescale 1ns/10ps
module ldca_top_tb;
  logic clk = 1'b0;
  logic ce = 1'b1;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, fstep, halt, irq;
  logic [9:0] load;
  logic [19:0] intv;
  logic [4:0] scale;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int run, lower, span, inc, dec, msel, lo, up, cnt, exp_scale, v, n, sum;
  int rate[4] = '{32, 8, 2, 1};
  logic [7:0] reg_adr[6] = '{ldca_pkg::ADDR_CONFIG, ldca_pkg::ADDR_ADAPT, ldca_pkg::ADDR_RUN_CURRENT,
    ldca_pkg::ADDR_VEL_THRESH, ldca_pkg::ADDR_ZERO_WAIT, 8'h30};
  logic [31:0] reg_rst[6] = '{32'h0, 32'h0, 32'h1F, 32'h0, 32'h0, 32'h0};

  initial begin
    forever #5 clk = ~clk;
  end

  ldca_top DUT (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CLK_EN(ce), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_FULLSTEP(fstep), .I_LOAD_SAMPLE(load), .I_STEP_INTERVAL(intv), .O_RAMP_HALT(halt),
    .O_CURRENT_SCALE(scale), .O_IRQ(irq));
  ldca_motor_model motor (.i_clk(clk), .i_halt(halt), .o_fullstep(fstep), .o_load(load), .o_interval(intv));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Classic single cycle; the request stands until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    // Only the bench cycle ceiling ends a wait for ack
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Next scale after one reading, from the threshold and step settings
  function automatic int adapt(input int s, input int val);
    int lim;
    lim = msel ? run >> 2 : run >> 1;
    if (val < lo) begin
      cnt = 0;
      return (s + (1 << inc) > run) ? run : s + (1 << inc);
    end
    cnt = (val < up) ? 0 : cnt + 1;
    if (cnt < rate[dec]) return s;
    cnt = 0;
    return (s <= lim) ? s : s - 1;
  endfunction : adapt

  initial begin
    n = $urandom(68644);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("scale after reset", 32'(scale), 32'h1F);
    foreach (reg_adr[i]) begin
      wb(reg_adr[i], 1'b0, 32'h0, q);
      chk("register reset", q, reg_rst[i]);
    end
    $display("test reset done");
    wb(ldca_pkg::ADDR_VEL_THRESH, 1'b1, 32'h3E8, q);
    for (int i = 0; i < 4; i++) begin
      v = 1 + $urandom % 1023;
      motor.step(v[9:0]);
      wait_cyc(4);
      wb(ldca_pkg::ADDR_LOAD_MEAS, 1'b0, 32'h0, q);
      chk("measurement", q, v);
    end
    wb(ldca_pkg::ADDR_CONFIG, 1'b1, 32'h1, q);
    sum = 0;
    for (int i = 0; i < 4; i++) begin
      n = $urandom % 1024;
      sum += n;
      motor.step(n[9:0]);
      wait_cyc(4);
      wb(ldca_pkg::ADDR_LOAD_MEAS, 1'b0, 32'h0, q);
      chk("filtered measurement", q, (i < 3) ? v : sum >> 2);
    end
    wb(ldca_pkg::ADDR_CONFIG, 1'b1, 32'h0, q);
    $display("test measurement done");
    run = 20;
    wb(ldca_pkg::ADDR_RUN_CURRENT, 1'b1, run, q);
    for (int it = 0; it < 4; it++) begin
      lower = 1 + $urandom % 15;
      span = $urandom % 16;
      inc = it;
      dec = (it + 2) % 4;
      msel = it & 1;
      lo = lower * 32;
      up = (lower + span + 1) * 32;
      wb(ldca_pkg::ADDR_ADAPT, 1'b1, 32'h0, q);
      motor.step(10'h005);
      wait_cyc(6);
      chk("scale adaptation off", 32'(scale), run);
      wb(ldca_pkg::ADDR_ADAPT, 1'b1, (msel << 12) | (dec << 10) | (inc << 8) | (span << 4) | lower, q);
      exp_scale = run;
      cnt = 0;
      for (int k = 0; k < 60; k++) begin
        n = $urandom % 20;
        case (k)
          0: v = up - 1;
          1: v = up;
          2: v = lo;
          3: v = lo - 1;
          default: v = n < 3 ? $urandom % lo : n < 6 ? lo + $urandom % (up - lo) : up + $urandom % (1024 - up);
        endcase
        motor.step(v[9:0]);
        exp_scale = adapt(exp_scale, v);
        wait_cyc(6);
        chk("current scale", 32'(scale), exp_scale);
      end
    end
    $display("test adaptation done");
    motor.speed_interval <= 20'h007D0;
    wb(ldca_pkg::ADDR_CONFIG, 1'b1, 32'h2, q);
    motor.step(10'h000);
    wait_cyc(8);
    chk("halt when slow", 32'(halt), 32'h0);
    chk("scale when slow", 32'(scale), run);
    motor.speed_interval <= 20'h00064;
    wb(ldca_pkg::ADDR_IRQ_MASK, 1'b1, 32'h1, q);
    wb(ldca_pkg::ADDR_ZERO_WAIT, 1'b1, 32'h8, q);
    motor.step(10'h000);
    while (halt !== 1'b1) @(posedge clk);
    wait_cyc(2);
    chk("halt on stall", 32'(halt), 32'h1);
    chk("stall interrupt", 32'(irq), 32'h1);
    wb(ldca_pkg::ADDR_DRIVER_STATUS_REGISTER, 1'b0, 32'h0, q);
    chk("stall flag", 32'(q[ldca_pkg::DRV_STALL_BIT]), 32'h1);
    wb(ldca_pkg::ADDR_IRQ_STATUS, 1'b0, 32'h0, q);
    chk("interrupt status", 32'(q[2:0]), 32'h7);
    wait_cyc(3);
    chk("interrupt after read", 32'(irq), 32'h0);
    wb(ldca_pkg::ADDR_RAMP_STATUS, 1'b0, 32'h0, q);
    chk("stall event", 32'(q[0]), 32'h1);
    wb(ldca_pkg::ADDR_RAMP_STATUS, 1'b1, q, q);
    wait_cyc(4);
    chk("halt during zero wait", 32'(halt), 32'h1);
    // Five frozen cycles push the restart past the point it would otherwise come
    ce <= 1'b0;
    wait_cyc(5);
    ce <= 1'b1;
    chk("halt held while frozen", 32'(halt), 32'h1);
    wait_cyc(12);
    chk("restart after zero wait", 32'(halt), 32'h0);
    wb(ldca_pkg::ADDR_DRIVER_STATUS_REGISTER, 1'b0, 32'h0, q);
    chk("stall flag after restart", 32'(q[ldca_pkg::DRV_STALL_BIT]), 32'h0);
    $display("test stall done");
    finish_test();
  end

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : wait_cyc
endmodule : ldca_top_tb
